// ### core/hss_port.sv
// High-speed serial port: processor I/O registers and 8N1 transceiver
`timescale 1ns/1ps
module hss_port
   import hss_pkg::*;
#(
   parameter int BAUD       = hss_pkg::BAUD_DEFAULT,  // Line rate in bit/s
   parameter bit PARITY_EN  = 1'b0,                   // Add a parity bit
   parameter bit PARITY_ODD = 1'b0                    // Odd parity when set
) (
   input  wire logic                i_ref_clk,        // 200 MHz clock
   input  wire logic                i_nrst,           // Async reset, low
   input  wire hss_pkg::hss_io_s    i_io,             // Processor I/O request
   output logic [7:0]               o_rdata,          // Read data
   output logic                     o_rdata_valid,    // Read answer strobe
   output hss_pkg::hss_ctrl_s       o_ctrl,           // Decoded control byte
   output logic                     o_rx_irq,         // Receive interrupt
   output logic                     o_tx_irq,         // Transmit interrupt
   input  wire logic                i_dma_done,       // DMA event from channel
   output logic                     o_dma_irq,        // DMA interrupt
   input  wire logic                i_self_test_led,  // Front-panel indicator
   input  wire logic                i_serial_rx,      // Serial in from host
   input  wire logic                i_cts,            // Host clear-to-send
   output logic                     o_serial_tx       // Serial out to host
);
   import hss_pkg::*;

   // Bit timing in clocks; a frame carries a parity bit only when enabled
   localparam int BIT_CYC  = CLK_HZ / ((BAUD > 0) ? BAUD : 1);
   localparam int HALF_CYC = BIT_CYC / 2;
   localparam int NBITS    = DATA_BITS + (PARITY_EN ? 1 : 0);

   // Elaboration checks: the bit counters are 16 bits wide and the receiver
   // needs at least two clocks in each half bit to find the middle of a bit
   if (BAUD <= 0) begin : g_bad_baud
      $error("hss_port: BAUD must be positive");
   end
   if (BIT_CYC < 4 || BIT_CYC > 65535) begin : g_bad_bit_cyc
      $error("hss_port: BAUD gives a bit time the counters cannot hold");
   end
   if (NBITS > 9) begin : g_bad_nbits
      $error("hss_port: frame longer than the shift registers");
   end

   // Bus decode, register flags and receiver hand-over signals
   logic        sel_data;
   logic        sel_ctrl;
   logic [7:0]  ctrl_q;
   logic [7:0]  rdata_q;
   logic        rvalid_q;
   logic [7:0]  txh_q;
   logic        txh_empty_q;
   logic [7:0]  rxb_q;
   logic        rx_wait_q;
   logic        ovr_q;
   logic        frm_q;
   logic        par_q;
   logic        dma_q;
   logic [7:0]  status;
   logic        tx_take;
   logic        rx_done;
   logic        rx_frm_err;
   logic        rx_par_err;
   logic [7:0]  rx_byte;

   // Address decode of the two ports
   assign sel_data = (i_io.addr == HSS_ADDR_DATA);
   assign sel_ctrl = (i_io.addr == HSS_ADDR_CTRL);

   // Control byte register
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_q <= CTL_RESET;
      end else if (i_io.wr && sel_ctrl) begin
         ctrl_q <= i_io.wdata;
      end
   end

   // Control fields steer DMA memory space and enables
   assign o_ctrl = hss_ctrl_s'(ctrl_q);

   // Transmit holding buffer
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         txh_q       <= BUF_RESET;
         txh_empty_q <= 1'b1;
      end else if (i_io.wr && sel_data) begin
         txh_q       <= i_io.wdata;
         txh_empty_q <= 1'b0;
      end else if (tx_take) begin
         txh_empty_q <= 1'b1;
      end
   end

   // Receive buffer and line error flags; a new arrival wins over a read clear
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rxb_q     <= BUF_RESET;
         rx_wait_q <= 1'b0;
         ovr_q     <= 1'b0;
         frm_q     <= 1'b0;
         par_q     <= 1'b0;
      end else if (rx_done) begin
         rxb_q     <= rx_byte;
         rx_wait_q <= 1'b1;
         ovr_q     <= rx_wait_q && !(i_io.rd && sel_data);
         frm_q     <= rx_frm_err;
         par_q     <= rx_par_err;
      end else if (i_io.rd && sel_data) begin
         rx_wait_q <= 1'b0;
      end
   end

   // DMA event latch, cleared by a control write, set wins
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         dma_q <= 1'b0;
      end else if (i_dma_done) begin
         dma_q <= 1'b1;
      end else if (i_io.wr && sel_ctrl) begin
         dma_q <= 1'b0;
      end
   end

   // Status byte
   assign status = {i_cts,
                    i_self_test_led,
                    ovr_q | frm_q | par_q,
                    par_q, frm_q, ovr_q,
                    txh_empty_q,
                    rx_wait_q};

   // Interrupt gating by control enables
   assign o_rx_irq  = rx_wait_q & ctrl_q[CTL_RX_IRQ];
   assign o_tx_irq  = txh_empty_q & ctrl_q[CTL_TX_IRQ];
   assign o_dma_irq = dma_q & ctrl_q[CTL_DMA_IRQ];

   // Registered read answer, one cycle after the request
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_q  <= BUF_RESET;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= i_io.rd && (sel_data || sel_ctrl);
         if (i_io.rd && sel_data) begin
            rdata_q <= rxb_q;
         end else if (i_io.rd && sel_ctrl) begin
            rdata_q <= status;
         end else begin
            rdata_q <= BUF_RESET;
         end
      end
   end
   assign o_rdata       = rdata_q;
   assign o_rdata_valid = rvalid_q;

   // Transmitter: start bit, data LSB first, optional parity, stop bit.
   // The holding buffer empties when the start bit is launched, so the
   // processor can queue the next byte during the whole frame.
   hss_state_e  tx_st_q;
   logic [15:0] tx_cnt_q;
   logic [3:0]  tx_bit_q;
   logic [8:0]  tx_sh_q;
   logic        tx_line_q;

   // A byte is taken only while the host grants clear-to-send
   assign tx_take = (tx_st_q == HSS_IDLE) && !txh_empty_q && i_cts;

   // Frame sequencer; start and data bits last BIT_CYC clocks each, stop at least one more; DATA holds the data and parity bits
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_st_q   <= HSS_IDLE;
         tx_cnt_q  <= 16'h0000;
         tx_bit_q  <= 4'h0;
         tx_sh_q   <= 9'h000;
         tx_line_q <= 1'b1;
      end else begin
         case (tx_st_q)
            HSS_IDLE: begin
               tx_line_q <= 1'b1;
               if (tx_take) begin
                  tx_sh_q   <= {^txh_q ^ PARITY_ODD, txh_q};
                  tx_st_q   <= HSS_START;
                  tx_cnt_q  <= 16'(BIT_CYC - 1);
                  tx_line_q <= 1'b0;
               end
            end
            HSS_START, HSS_DATA: begin
               if (tx_cnt_q != 16'h0000) begin
                  tx_cnt_q <= tx_cnt_q - 16'h0001;
               end else if (tx_st_q == HSS_START || tx_bit_q != 4'(NBITS)) begin
                  tx_line_q <= tx_sh_q[0];
                  tx_sh_q   <= {1'b1, tx_sh_q[8:1]};
                  tx_bit_q  <= tx_bit_q + 4'h1;
                  tx_st_q   <= HSS_DATA;
                  tx_cnt_q  <= 16'(BIT_CYC - 1);
               end else begin
                  tx_line_q <= 1'b1;
                  tx_st_q   <= HSS_STOP;
                  tx_cnt_q  <= 16'(BIT_CYC - 1);
               end
            end
            HSS_STOP: begin
               if (tx_cnt_q != 16'h0000) begin
                  tx_cnt_q <= tx_cnt_q - 16'h0001;
               end else begin
                  tx_st_q  <= HSS_IDLE;
                  tx_bit_q <= 4'h0;
               end
            end
            default: tx_st_q <= HSS_IDLE;
         endcase
      end
   end
   // Line output comes straight from a flip-flop, free of glitches
   assign o_serial_tx = tx_line_q;

   // Receiver: the start bit is checked at its middle, so a short low
   // glitch on an idle line returns to idle without a character.
   hss_state_e  rx_st_q;
   logic [15:0] rx_cnt_q;
   logic [3:0]  rx_bit_q;
   logic [8:0]  rx_sh_q;
   logic        rx_done_q;
   logic        rx_frm_q;

   // Bit sampler; data bits are taken one bit time apart from mid-start
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rx_st_q   <= HSS_IDLE;
         rx_cnt_q  <= 16'h0000;
         rx_bit_q  <= 4'h0;
         rx_sh_q   <= 9'h000;
         rx_done_q <= 1'b0;
         rx_frm_q  <= 1'b0;
      end else begin
         rx_done_q <= 1'b0;
         case (rx_st_q)
            HSS_IDLE: begin
               rx_bit_q <= 4'h0;
               if (!i_serial_rx) begin
                  rx_st_q  <= HSS_START;
                  rx_cnt_q <= 16'(HALF_CYC - 1);
               end
            end
            HSS_START: begin
               if (rx_cnt_q != 16'h0000) begin
                  rx_cnt_q <= rx_cnt_q - 16'h0001;
               end else if (i_serial_rx) begin
                  rx_st_q <= HSS_IDLE;              // Glitch, not a start bit
               end else begin
                  rx_st_q  <= HSS_DATA;
                  rx_cnt_q <= 16'(BIT_CYC - 1);
               end
            end
            HSS_DATA: begin
               if (rx_cnt_q != 16'h0000) begin
                  rx_cnt_q <= rx_cnt_q - 16'h0001;
               end else begin
                  rx_sh_q  <= {i_serial_rx, rx_sh_q[8:1]};
                  rx_bit_q <= rx_bit_q + 4'h1;
                  rx_cnt_q <= 16'(BIT_CYC - 1);
                  if (rx_bit_q == 4'(NBITS - 1)) begin
                     rx_st_q <= HSS_STOP;
                  end
               end
            end
            HSS_STOP: begin
               if (rx_cnt_q != 16'h0000) begin
                  rx_cnt_q <= rx_cnt_q - 16'h0001;
               end else begin
                  rx_frm_q  <= !i_serial_rx;
                  rx_done_q <= 1'b1;
                  rx_st_q   <= HSS_IDLE;
               end
            end
            default: rx_st_q <= HSS_IDLE;
         endcase
      end
   end

   // Align received bits: without parity the byte sits in the upper bits
   assign rx_byte    = PARITY_EN ? rx_sh_q[7:0] : rx_sh_q[8:1];
   assign rx_done    = rx_done_q;
   assign rx_frm_err = rx_frm_q;
   assign rx_par_err = PARITY_EN && ((^rx_sh_q) != PARITY_ODD);
endmodule : hss_port

// ### pkg/hss_pkg.sv
// Package for the high-speed serial port: addresses, fields, timing, types
package hss_pkg;
   // Port addresses on the processor I/O bus
   localparam logic [7:0] HSS_ADDR_DATA = 8'hE8;
   localparam logic [7:0] HSS_ADDR_CTRL = 8'hE9;
   // Control byte field positions
   localparam int CTL_CH0_SYS   = 0;
   localparam int CTL_RX_IRQ    = 1;
   localparam int CTL_TX_IRQ    = 2;
   localparam int CTL_DMA_IRQ   = 3;
   localparam int CTL_DMA_FROM  = 4;
   localparam int CTL_DMA_TO    = 5;
   localparam int CTL_CH1_SYS   = 6;
   localparam int CTL_CH2_SYS   = 7;
   // Reset values
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] BUF_RESET = 8'h00;
   // Serial timing
   localparam int CLK_HZ        = 200_000_000;
   localparam int BAUD_DEFAULT  = 115_200;
   localparam int DATA_BITS     = 8;

   typedef enum logic [1:0] {
      HSS_IDLE,
      HSS_START,
      HSS_DATA,
      HSS_STOP
   } hss_state_e;

   // Control byte decoded to named steering outputs
   typedef struct packed {
      logic ch2_sys_mem;
      logic ch1_sys_mem;
      logic dma_to_memory_enable;
      logic dma_from_memory_enable;
      logic dma_irq_enable;
      logic serial_out_irq_enable;
      logic serial_in_irq_enable;
      logic ch0_sys_mem;
   } hss_ctrl_s;

   // Processor I/O bus request
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hss_io_s;
endpackage : hss_pkg

// ### testbench/hss_host_model.sv
// Host computer model: 8N1 sender, receiver and clear-to-send
`timescale 1ns/1ps
module hss_host_model #(
   parameter int BIT_CYC = 10  // Clocks per bit
) (
   input  wire logic i_ref_clk, // Clock
   input  wire logic i_line,    // Serial from the port
   output logic      o_line,    // Serial to the port
   output logic      o_cts,     // Clear-to-send
   output logic [7:0] o_got,    // Last byte caught
   output int        o_got_cnt  // Bytes caught
);
   // Idle line high, not clear until told
   initial begin
      o_line = 1'b1;
      o_cts = 1'b0;
      o_got = 8'h00;
      o_got_cnt = 0;
   end
   // Grant or withhold clear-to-send
   task automatic clear(input logic c);
      o_cts <= c;
   endtask : clear
   // Send one frame, LSB first, stop level chosen by caller
   task automatic send(input logic [7:0] b, input logic stop);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      @(posedge i_ref_clk);
      for (int i = 0; i < 10; i++) begin
         o_line <= f[i];
         repeat (BIT_CYC) @(posedge i_ref_clk);
      end
      o_line <= 1'b1;
   endtask : send
   // Catch frames from the port, sampling mid-bit
   initial begin
      forever begin
         @(negedge i_line);
         repeat (BIT_CYC / 2) @(posedge i_ref_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge i_ref_clk);
            o_got[i] = i_line;
         end
         repeat (BIT_CYC) @(posedge i_ref_clk);
         o_got_cnt++;
      end
   end
endmodule : hss_host_model

// ### testbench/hss_port_asserts.sv
// Port-level assertion checker for the high-speed serial port
`timescale 1ns/1ps
module hss_port_asserts
   import hss_pkg::*;
(
   input wire logic               i_ref_clk,       // Clock
   input wire logic               i_nrst,          // Reset, low
   input wire hss_pkg::hss_io_s   i_io,            // I/O request
   input wire logic [7:0]         o_rdata,         // Read data
   input wire logic               o_rdata_valid,   // Read strobe
   input wire hss_pkg::hss_ctrl_s o_ctrl,          // Control byte
   input wire logic               o_rx_irq,        // Receive irq
   input wire logic               o_tx_irq,        // Transmit irq
   input wire logic               i_dma_done,      // DMA event
   input wire logic               o_dma_irq,       // DMA irq
   input wire logic               i_self_test_led, // Indicator
   input wire logic               i_serial_rx,     // Serial in
   input wire logic               i_cts,           // Clear-to-send
   input wire logic               o_serial_tx      // Serial out
);
   import hss_pkg::*;
   logic rd_hit;
   logic st_rd;
   logic ctl_wr;
   // Decoded accesses
   assign rd_hit = i_io.rd && (i_io.addr == HSS_ADDR_DATA || i_io.addr == HSS_ADDR_CTRL);
   assign st_rd  = i_io.rd && i_io.addr == HSS_ADDR_CTRL;
   assign ctl_wr = i_io.wr && i_io.addr == HSS_ADDR_CTRL;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   a_read_answer: assert property (rd_hit |=> o_rdata_valid)
      else $error("read not answered");
   a_no_stray: assert property (o_rdata_valid |-> $past(rd_hit))
      else $error("answer without read");
   a_ctrl_load: assert property (ctl_wr |=> o_ctrl == $past(i_io.wdata))
      else $error("control byte not loaded");
   a_ctrl_hold: assert property (!ctl_wr |=> $stable(o_ctrl))
      else $error("control byte changed");
   a_cts_status: assert property (st_rd |=> o_rdata[7] == $past(i_cts))
      else $error("status cts wrong");
   a_led_status: assert property (st_rd |=> o_rdata[6] == $past(i_self_test_led))
      else $error("status indicator wrong");
   a_err_summary: assert property (st_rd |=> o_rdata[5] == |o_rdata[4:2])
      else $error("error summary wrong");
   a_rx_irq_gate: assert property (o_rx_irq |-> o_ctrl.serial_in_irq_enable)
      else $error("receive irq while masked");
   a_dma_irq_gate: assert property (o_dma_irq |-> o_ctrl.dma_irq_enable)
      else $error("dma irq while masked");
   c_status_read: cover property (st_rd ##1 o_rdata[0]);
   c_ctrl_write: cover property (ctl_wr);
   c_dma_irq: cover property (o_dma_irq);
endmodule : hss_port_asserts

bind hss_port hss_port_asserts i_chk (.i_ref_clk, .i_nrst, .i_io, .o_rdata, .o_rdata_valid,
   .o_ctrl, .o_rx_irq, .o_tx_irq, .i_dma_done, .o_dma_irq, .i_self_test_led, .i_serial_rx,
   .i_cts, .o_serial_tx);

// ### testbench/tb_high_speed_serial_port.sv
// Testbench for the high-speed serial port
`timescale 1ns/1ps
module tb_high_speed_serial_port;
   import hss_pkg::*;
   logic       i_ref_clk       = 1'b0;
   logic       i_nrst          = 1'b0;
   hss_io_s    i_io            = '0;
   logic       i_dma_done      = 1'b0;
   logic       i_self_test_led = 1'b1;
   logic [7:0] o_rdata;
   logic       o_rdata_valid;
   hss_ctrl_s  o_ctrl;
   logic       o_rx_irq;
   logic       o_tx_irq;
   logic       o_dma_irq;
   logic       o_serial_tx;
   logic       rx_line;
   logic       cts;
   logic [7:0] got;
   int         got_cnt;
   int         mismatches      = 0;
   int         check_count     = 0;
   int         cycles          = 0;
   logic [7:0] d;
   logic       v;
   // 10 clocks per bit
   hss_port #(.BAUD(20_000_000)) i_dut (.i_ref_clk, .i_nrst, .i_io, .o_rdata, .o_rdata_valid,
      .o_ctrl, .o_rx_irq, .o_tx_irq, .i_dma_done, .o_dma_irq, .i_self_test_led,
      .i_serial_rx(rx_line), .i_cts(cts), .o_serial_tx);
   hss_host_model #(.BIT_CYC(10)) i_host (.i_ref_clk, .i_line(o_serial_tx), .o_line(rx_line),
      .o_cts(cts), .o_got(got), .o_got_cnt(got_cnt));
   // 200 MHz clock
   always #2.5 i_ref_clk = ~i_ref_clk;
   // Hang guard: the tests need well under 1,000 clocks
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 5_000) begin
         mismatches++;
         test_done();
      end
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // One-cycle write; returns just after the taking edge
   task automatic io_wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge i_ref_clk);
      i_io <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: w};
      @(posedge i_ref_clk);
      i_io <= '0;
      #1;
   endtask : io_wr
   // One-cycle read; answer sampled in the cycle after the taking edge
   task automatic io_rd(input logic [7:0] a, output logic [7:0] r, output logic rv);
      @(posedge i_ref_clk);
      i_io <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge i_ref_clk);
      i_io <= '0;
      #1;
      r = o_rdata;
      rv = o_rdata_valid;
   endtask : io_rd
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      io_rd(a, d, v);
      chk({7'h0, v}, 8'h01);
      chk(d, e);
   endtask : rd_chk
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      rd_chk(HSS_ADDR_CTRL, 8'h42);
      // Self-test indicator followed in status bit 6
      @(posedge i_ref_clk);
      i_self_test_led <= 1'b0;
      rd_chk(HSS_ADDR_CTRL, 8'h02);
      @(posedge i_ref_clk);
      i_self_test_led <= 1'b1;
      // Walk each control bit alone
      for (int i = 0; i < 8; i++) begin
         io_wr(HSS_ADDR_CTRL, 8'h01 << i);
         chk(o_ctrl, 8'h01 << i);
         chk({7'h0, o_tx_irq}, {7'h0, i == 2});
      end
      // DMA event raises irq; a control write clears it with the enable kept
      io_wr(HSS_ADDR_CTRL, 8'h08);
      @(posedge i_ref_clk);
      i_dma_done <= 1'b1;
      @(posedge i_ref_clk);
      i_dma_done <= 1'b0;
      @(posedge i_ref_clk);
      #1;
      chk({7'h0, o_dma_irq}, 8'h01);
      io_wr(HSS_ADDR_CTRL, 8'h0A);
      chk({7'h0, o_dma_irq}, 8'h00);
      io_rd(8'hEA, d, v);
      chk({7'h0, v}, 8'h00);
      // Transmit held back until host is clear
      io_wr(HSS_ADDR_DATA, 8'hA5);
      rd_chk(HSS_ADDR_CTRL, 8'h40);
      repeat (30) @(posedge i_ref_clk);
      #1;
      chk({7'h0, o_serial_tx}, 8'h01);
      @(posedge i_ref_clk);
      i_host.clear(1'b1);
      for (int k = 0; k < 300 && got_cnt == 0; k++) @(posedge i_ref_clk);
      chk(got, 8'hA5);
      rd_chk(HSS_ADDR_CTRL, 8'hC2);
      // Clean receive, then framing error, then overrun
      i_host.send(8'h3C, 1'b1);
      #1;
      chk({7'h0, o_rx_irq}, 8'h01);
      rd_chk(HSS_ADDR_CTRL, 8'hC3);
      rd_chk(HSS_ADDR_DATA, 8'h3C);
      rd_chk(HSS_ADDR_CTRL, 8'hC2);
      i_host.send(8'h55, 1'b0);
      repeat (10) @(posedge i_ref_clk);
      rd_chk(HSS_ADDR_CTRL, 8'hEB);
      rd_chk(HSS_ADDR_DATA, 8'h55);
      i_host.send(8'h11, 1'b1);
      i_host.send(8'h22, 1'b1);
      rd_chk(HSS_ADDR_CTRL, 8'hE7);
      test_done();
   end
endmodule : tb_high_speed_serial_port
